// *** pkg/mods_pkg.sv ***
// Constants, field layouts and types for the operation data select and status block.
// Assumes one 100 MHz clock and a classic Wishbone slave port with 32-bit data.
// Notes on behaviour
// - Speed-attained output is on while detected speed is within commanded speed plus/minus width; the code also requires run enable to be on.
// - Detection width is configurable from 1 to 400 r/min, default 200.
// - One information bit output per information type, on while the condition holds.
// - Eight operation data sets 0..7, each speed, accel time, decel time, torque limit.
// - Acceleration time is the ramp time from standstill to 3000 r/min.
// - Deceleration time is the ramp time from 3000 r/min to standstill.
// - Torque limit is a percentage where rated torque is 100.
// - Changes to value-source selections take effect only once the motor has stopped.
// - Set 0 speed external, set 1 speed pot one, ramps pot two; others digital.
// - Speed and torque sources of one set must not share a non-digital source.
// - A shared non-digital source raises the data setting error information.
// - Running a set that causes the setting error raises run-prohibited instead; the code raises run-prohibited and keeps the setting error raised too.
// - A separate parameter picks analog device or PWM input for the external source.
// - Digital speed accepts 80 to 3150 r/min, default 80.
// - Three select inputs form the set number, bit 2 most significant.
// - Summary output is on when any enabled information condition is active.
package mods_pkg;

  localparam int unsigned NSETS      = 8;
  localparam int unsigned NINFO      = 17;
  localparam int unsigned SPD_W      = 12;
  localparam int unsigned TIME_W     = 8;
  localparam int unsigned TRQ_W      = 8;

  // Register word offsets (byte addresses).
  localparam logic [7:0] OFS_WIDTH   = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_MOTOR   = 8'h08;
  localparam logic [7:0] OFS_SUMMARY_OUT_A_EN = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_SUMMARY_OUT_A    = 8'h14;
  localparam logic [7:0] OFS_SET0    = 8'h20;
  localparam logic [7:0] OFS_SRC0    = 8'h40;
  localparam logic [7:0] OFS_ACTIVE0 = 8'h60;
  localparam logic [7:0] OFS_HOLD    = 8'h80;

  // Set data word fields: speed [11:0], accel [19:12], decel [27:20]; torque in hold word.
  localparam int unsigned F_SPD_LSB  = 0;
  localparam int unsigned F_ACC_LSB  = 12;
  localparam int unsigned F_DEC_LSB  = 20;
  localparam int unsigned F_TRQ_LSB  = 0;
  // Source word fields: speed [1:0], torque [3:2], accel [5:4], decel [7:6].
  localparam int unsigned F_SSPD_LSB = 0;
  localparam int unsigned F_STRQ_LSB = 2;
  localparam int unsigned F_SACC_LSB = 4;
  localparam int unsigned F_SDEC_LSB = 6;

  localparam logic [SPD_W-1:0] WIDTH_MIN  = 12'd1;
  localparam logic [SPD_W-1:0] WIDTH_MAX  = 12'd400;
  localparam logic [SPD_W-1:0] WIDTH_RST  = 12'd200;
  localparam logic [SPD_W-1:0] SPD_MIN    = 12'd80;
  localparam logic [SPD_W-1:0] SPD_MAX    = 12'd3150;
  localparam logic [SPD_W-1:0] SPD_RST    = 12'd80;
  localparam logic [SPD_W-1:0] RAMP_REF   = 12'd3000;
  localparam logic [TIME_W-1:0] TIME_RST  = 8'h05;
  localparam logic [TRQ_W-1:0] TRQ_RATED  = 8'd100;
  localparam logic [TRQ_W-1:0] TRQ_RST    = 8'd200;

  typedef enum logic [1:0] {SRC_DIGITAL, SRC_POT_ONE, SRC_POT_TWO, SRC_EXTERNAL} mods_src_e;

  // Information bit positions.
  localparam int unsigned I_SET_E = 5;
  localparam int unsigned I_DRV   = 6;

endpackage

// *** src/mods_core.sv ***
// Operation data store, source selection, conflict check and status outputs.
// Assumes a classic Wishbone master on clk_i; raw select pins come from outside the clock.
`timescale 1ns/10ps
module mods_core (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        data_select_bit0_i,
  input  wire logic                        data_select_bit1_i,
  input  wire logic                        data_select_bit2_i,
  input  wire logic [mods_pkg::SPD_W-1:0]  detected_speed_i,
  input  wire logic                        motor_stopped_i,
  input  wire logic                        run_request_i,
  input  wire logic [mods_pkg::NINFO-1:0]  summary_out_a_cond_i,
  output logic                             speed_attained_out_o,
  output logic                             summary_out_a_o,
  output logic      [mods_pkg::NINFO-1:0]  summary_out_a_bits_o,
  output logic                             run_enable_o,
  output logic      [2:0]                  active_set_o,
  output logic      [mods_pkg::SPD_W-1:0]  cmd_speed_o,
  output logic      [mods_pkg::TIME_W-1:0] accel_time_o,
  output logic      [mods_pkg::TIME_W-1:0] decel_time_o,
  output logic      [mods_pkg::TRQ_W-1:0]  torque_limit_o,
  output logic      [7:0]                  active_src_o,
  output logic                             ext_pwm_sel_o
);
  import mods_pkg::*;

  typedef struct packed {
    logic [2:0]               sel_m;
    logic [2:0]               sel_s;
    logic [SPD_W-1:0]         width;
    logic                     ext_pwm;
    logic [NINFO-1:0]         summary_out_a_en;
    logic [NSETS-1:0][SPD_W-1:0]  spd;
    logic [NSETS-1:0][TIME_W-1:0] acc;
    logic [NSETS-1:0][TIME_W-1:0] dec;
    logic [NSETS-1:0][TRQ_W-1:0]  trq;
    logic [NSETS-1:0][7:0]    src_pend;
    logic [NSETS-1:0][7:0]    src_act;
    logic                     ack;
    logic [31:0]              rdat;
    logic                     va;
    logic                     summ;
    logic [NINFO-1:0]         summary_out_a;
    logic                     run_en;
    logic [SPD_W-1:0]         cmd_spd;
    logic [TIME_W-1:0]        acc_out;
    logic [TIME_W-1:0]        dec_out;
    logic [TRQ_W-1:0]         trq_out;
    logic [7:0]               src_out;
  } mods_state_s;

  mods_state_s s_q;
  mods_state_s s_d;
  logic [NSETS-1:0] conflict;
  logic [2:0]       idx;
  logic [7:0]       cur_src;
  logic [SPD_W:0]   lo_lim;
  logic [SPD_W:0]   hi_lim;
  logic [NINFO-1:0] cond;

  // Conflict per set on the active source selection.
  genvar g;
  generate
    for (g = 0; g < NSETS; g++)
    begin : g_conf
      assign conflict[g] = (s_q.src_act[g][F_SSPD_LSB +: 2] != 2'(SRC_DIGITAL)) &&
                           (s_q.src_act[g][F_SSPD_LSB +: 2] ==
                            s_q.src_act[g][F_STRQ_LSB +: 2]);
    end
  endgenerate

  function automatic logic [7:0] src_reset(input int unsigned n);
    logic [7:0] r;
    r = '0;
    if (n == 0)
      r = {2'(SRC_POT_TWO), 2'(SRC_POT_TWO), 2'(SRC_DIGITAL), 2'(SRC_EXTERNAL)};
    else if (n == 1)
      r = {2'(SRC_POT_TWO), 2'(SRC_POT_TWO), 2'(SRC_DIGITAL), 2'(SRC_POT_ONE)};
    return r;
  endfunction

  always_comb
  begin
    s_d = s_q;
    idx = wb_adr_i[4:2];
    s_d.sel_m = {data_select_bit2_i, data_select_bit1_i, data_select_bit0_i};
    s_d.sel_s = s_q.sel_m;
    // Wishbone slave: one wait state, ack dropped the cycle after it is given.
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.rdat = '0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack)
    begin
      if (wb_adr_i[7:5] == OFS_SET0[7:5])
        s_d.rdat = {4'h0, s_q.dec[idx], s_q.acc[idx], s_q.spd[idx]};
      else if (wb_adr_i[7:5] == OFS_SRC0[7:5])
        s_d.rdat = {24'h0, s_q.src_pend[idx]};
      else if (wb_adr_i[7:5] == OFS_ACTIVE0[7:5])
        s_d.rdat = {24'h0, s_q.src_act[idx]};
      else if (wb_adr_i[7:5] == OFS_HOLD[7:5])
        s_d.rdat = {24'h0, s_q.trq[idx]};
      else
        case (wb_adr_i)
          OFS_WIDTH:   s_d.rdat = {20'h0, s_q.width};
          OFS_CTRL:    s_d.rdat = {31'h0, s_q.ext_pwm};
          OFS_MOTOR:   s_d.rdat = {20'h0, s_q.run_en, s_q.sel_s, conflict};
          OFS_SUMMARY_OUT_A_EN: s_d.rdat = {15'h0, s_q.summary_out_a_en};
          OFS_STATUS:  s_d.rdat = {30'h0, s_q.summ, s_q.va};
          OFS_SUMMARY_OUT_A:    s_d.rdat = {15'h0, s_q.summary_out_a};
          default:     s_d.rdat = '0;
        endcase
      if (wb_we_i && wb_sel_i[0])
      begin
        if (wb_adr_i[7:5] == OFS_SET0[7:5])
        begin
          if (wb_sel_i[1] && wb_dat_i[11:0] >= SPD_MIN && wb_dat_i[11:0] <= SPD_MAX)
            s_d.spd[idx] = wb_dat_i[F_SPD_LSB +: SPD_W];
          if (wb_sel_i[2])
          begin
            s_d.acc[idx] = wb_dat_i[F_ACC_LSB +: TIME_W];
            s_d.dec[idx] = wb_dat_i[F_DEC_LSB +: TIME_W];
          end
        end
        else if (wb_adr_i[7:5] == OFS_SRC0[7:5])
          s_d.src_pend[idx] = wb_dat_i[7:0];
        else if (wb_adr_i[7:5] == OFS_HOLD[7:5])
          s_d.trq[idx] = wb_dat_i[F_TRQ_LSB +: TRQ_W];
        else if (wb_adr_i == OFS_WIDTH && wb_sel_i[1] &&
                 wb_dat_i[11:0] >= WIDTH_MIN && wb_dat_i[11:0] <= WIDTH_MAX)
          s_d.width = wb_dat_i[SPD_W-1:0];
        else if (wb_adr_i == OFS_CTRL)
          s_d.ext_pwm = wb_dat_i[0];
        else if (wb_adr_i == OFS_SUMMARY_OUT_A_EN && wb_sel_i[2])
          s_d.summary_out_a_en = wb_dat_i[NINFO-1:0];
      end
    end
    // Source changes are only copied into the active set while stopped.
    if (motor_stopped_i)
      s_d.src_act = s_q.src_pend;
    cur_src = s_q.src_act[s_q.sel_s];
    lo_lim = {1'b0, s_q.spd[s_q.sel_s]} - {1'b0, s_q.width};
    hi_lim = {1'b0, s_q.spd[s_q.sel_s]} + {1'b0, s_q.width};
    if (s_q.width > s_q.spd[s_q.sel_s])
      lo_lim = '0;
    // Window compare is re-evaluated every cycle so it drops while ramping.
    s_d.va = s_q.run_en && ({1'b0, detected_speed_i} >= lo_lim) &&
             ({1'b0, detected_speed_i} <= hi_lim);
    cond = summary_out_a_cond_i;
    cond[I_SET_E] = summary_out_a_cond_i[I_SET_E] | (|conflict);
    cond[I_DRV] = summary_out_a_cond_i[I_DRV] | (run_request_i && conflict[s_q.sel_s]);
    s_d.summary_out_a = cond;
    s_d.summ = |(cond & s_q.summary_out_a_en);
    s_d.run_en = run_request_i && !conflict[s_q.sel_s];
    // Selected set values are registered so every output leaves a flip-flop.
    s_d.cmd_spd = s_q.spd[s_q.sel_s];
    s_d.acc_out = s_q.acc[s_q.sel_s];
    s_d.dec_out = s_q.dec[s_q.sel_s];
    s_d.trq_out = s_q.trq[s_q.sel_s];
    s_d.src_out = s_q.src_act[s_q.sel_s];
    if (rst_i)
    begin
      s_d = '0;
      s_d.width = WIDTH_RST;
      s_d.summary_out_a_en = '1;
      s_d.cmd_spd = SPD_RST;
      s_d.acc_out = TIME_RST;
      s_d.dec_out = TIME_RST;
      s_d.trq_out = TRQ_RST;
      s_d.src_out = src_reset(0);
      for (int n = 0; n < NSETS; n++)
      begin
        s_d.spd[n] = SPD_RST;
        s_d.acc[n] = TIME_RST;
        s_d.dec[n] = TIME_RST;
        s_d.trq[n] = TRQ_RST;
        s_d.src_pend[n] = src_reset(n);
        s_d.src_act[n] = src_reset(n);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    s_q <= s_d;
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign speed_attained_out_o = s_q.va;
  assign summary_out_a_o = s_q.summ;
  assign summary_out_a_bits_o = s_q.summary_out_a;
  assign run_enable_o = s_q.run_en;
  assign active_set_o = s_q.sel_s;
  assign cmd_speed_o = s_q.cmd_spd;
  assign accel_time_o = s_q.acc_out;
  assign decel_time_o = s_q.dec_out;
  assign torque_limit_o = s_q.trq_out;
  assign active_src_o = s_q.src_out;
  assign ext_pwm_sel_o = s_q.ext_pwm;

  a_va_window: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_attained_out_o |-> $past(run_enable_o))
    else $error("speed attained without run");
  a_va_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(detected_speed_i) > cmd_speed_o + s_q.width) && $stable(cmd_speed_o)
      && $stable(s_q.width) |-> !speed_attained_out_o)
    else $error("speed attained outside window");
  a_width_range: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.width >= WIDTH_MIN && s_q.width <= WIDTH_MAX)
    else $error("width out of range");
  a_speed_range: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_speed_o >= SPD_MIN && cmd_speed_o <= SPD_MAX)
    else $error("digital speed out of range");
  a_src_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(motor_stopped_i) |-> $stable(s_q.src_act))
    else $error("source changed while running");
  a_set_err: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(|conflict) |-> summary_out_a_bits_o[I_SET_E])
    else $error("setting error not raised");
  a_run_block: assert property (@(posedge clk_i) disable iff (rst_i)
    run_enable_o |-> !summary_out_a_bits_o[I_DRV] || $past(summary_out_a_cond_i[I_DRV]))
    else $error("ran with conflicting set");
  a_sel_track: assert property (@(posedge clk_i) disable iff (rst_i)
    ##2 active_set_o == $past({data_select_bit2_i, data_select_bit1_i,
                                data_select_bit0_i}, 2))
    else $error("select not tracked");
  a_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    summary_out_a_o |-> |(summary_out_a_bits_o & $past(s_q.summary_out_a_en)))
    else $error("summary without cause");
endmodule // mods_core

// *** tb/mods_ctrl_model.sv ***
// Model of the external controller that picks the active operation data set.
// Assumes one clock shared with the block; pins change just after a rising edge.
`timescale 1ns/10ps
module mods_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] set_num_i,
  output logic            sel_bit0_o,
  output logic            sel_bit1_o,
  output logic            sel_bit2_o
);
  initial
  begin
    sel_bit0_o = 1'b0;
    sel_bit1_o = 1'b0;
    sel_bit2_o = 1'b0;
  end
  // The set number goes out as plain binary, the third pin carrying the top bit.
  always @(posedge clk_i)
  begin
    sel_bit0_o <= set_num_i[0];
    sel_bit1_o <= set_num_i[1];
    sel_bit2_o <= set_num_i[2];
  end
endmodule // mods_ctrl_model

// *** tb/motor_operation_data_select_status_test.sv ***
// Self-checking bench for the operation data select and status block.
// Assumes a 100 MHz clock and a Wishbone slave that acks one cycle after taking a request.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module motor_operation_data_select_status_test;
  import mods_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, s0, s1, s2, va, summ, run_en, pwm;
  logic [2:0] set_num = 3'h0, act_set;
  logic [SPD_W-1:0] det_spd = 12'h000, cmd_spd;
  logic stopped = 1'b1, run_req = 1'b0;
  logic [NINFO-1:0] cond = '0, summary_out_a;
  logic [7:0] acc, dec, trq, asrc;
  int err_count = 0, checks_done = 0;
  initial forever #5 clk_i = ~clk_i;
  mods_ctrl_model u_mods_ctrl_model (.clk_i(clk_i), .set_num_i(set_num), .sel_bit0_o(s0),
    .sel_bit1_o(s1), .sel_bit2_o(s2));
  mods_core u_mods_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .data_select_bit0_i(s0), .data_select_bit1_i(s1),
    .data_select_bit2_i(s2), .detected_speed_i(det_spd), .motor_stopped_i(stopped),
    .run_request_i(run_req), .summary_out_a_cond_i(cond), .speed_attained_out_o(va),
    .summary_out_a_o(summ), .summary_out_a_bits_o(summary_out_a), .run_enable_o(run_en),
    .active_set_o(act_set), .cmd_speed_o(cmd_spd), .accel_time_o(acc),
    .decel_time_o(dec), .torque_limit_o(trq), .active_src_o(asrc), .ext_pwm_sel_o(pwm));
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, q & m)
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("width rst", OFS_WIDTH, 32'hfff, 32'd200);
    rd_chk("set2 rst", OFS_SET0 + 8'h08, 32'h0fffffff, 32'h00505050);
    rd_chk("trq rst", OFS_HOLD, 32'hff, 32'd200);
    rd_chk("src0 rst", OFS_ACTIVE0, 32'hff, 32'ha3);
    rd_chk("src1 rst", OFS_ACTIVE0 + 8'h04, 32'hff, 32'ha1);
    rd_chk("src2 rst", OFS_ACTIVE0 + 8'h08, 32'hff, 32'h00);
    rd_chk("unmapped", 8'hfc, 32'hffffffff, 32'h0);
    wb(1'b1, OFS_WIDTH, 32'd401); rd_chk("width 401", OFS_WIDTH, 32'hfff, 32'd200);
    wb(1'b1, OFS_WIDTH, 32'd0); rd_chk("width 0", OFS_WIDTH, 32'hfff, 32'd200);
    wb(1'b1, OFS_WIDTH, 32'd400); rd_chk("width 400", OFS_WIDTH, 32'hfff, 32'd400);
    wb(1'b1, OFS_WIDTH, 32'd1); rd_chk("width 1", OFS_WIDTH, 32'hfff, 32'd1);
    wb(1'b1, OFS_SET0 + 8'h0c, 32'd79); rd_chk("spd 79", OFS_SET0 + 8'h0c, 32'hfff, 32'd80);
    wb(1'b1, OFS_SET0 + 8'h0c, 32'd3151); rd_chk("spd hi", OFS_SET0 + 8'h0c, 32'hfff, 32'd80);
    wb(1'b1, OFS_SET0 + 8'h0c, 32'd3150); rd_chk("spd max", OFS_SET0 + 8'h0c, 32'hfff, 32'd3150);
    wb(1'b1, OFS_SET0 + 8'h0c, 32'h0140a3e8);
    wb(1'b1, OFS_HOLD + 8'h0c, 32'd100);
    for (int s = 0; s < 8; s++)
    begin
      set_num <= 3'(s);
      settle();
      `CHK("active set", 3'(s), act_set)
      rd_chk("set reg", OFS_MOTOR, 32'h700, 32'(s) << 8);
    end
    set_num <= 3'h3; run_req <= 1'b1; stopped <= 1'b0; det_spd <= 12'd1000;
    settle();
    `CHK("cmd spd", 12'd1000, cmd_spd)
    `CHK("accel", 8'h0a, acc)
    `CHK("decel", 8'h14, dec)
    `CHK("torque", TRQ_RATED, trq)
    `CHK("run en", 1'b1, run_en)
    foreach (cond[i]) begin end
    for (int k = 0; k < 4; k++)
    begin
      det_spd <= (k < 2) ? 12'(999 + 2 * k) : 12'(998 + 4 * (k - 2));
      settle();
      `CHK("attained", (k < 2), va)
    end
    wb(1'b1, OFS_SRC0 + 8'h0c, 32'h05);
    settle();
    rd_chk("src held", OFS_ACTIVE0 + 8'h0c, 32'hff, 32'h00);
    `CHK("no set err", 1'b0, summary_out_a[I_SET_E])
    stopped <= 1'b1;
    settle();
    rd_chk("src moved", OFS_ACTIVE0 + 8'h0c, 32'hff, 32'h05);
    rd_chk("conflict", OFS_MOTOR, 32'h8, 32'h8);
    `CHK("set err", 1'b1, summary_out_a[I_SET_E])
    `CHK("prohibited", 1'b1, summary_out_a[I_DRV])
    `CHK("no run", 1'b0, run_en)
    `CHK("summary", 1'b1, summ)
    cond <= 17'h00001;
    settle();
    `CHK("summary_out_a bit0", 1'b1, summary_out_a[0])
    wb(1'b1, OFS_SUMMARY_OUT_A_EN, 32'h0);
    settle();
    `CHK("summary off", 1'b0, summ)
    wb(1'b1, OFS_CTRL, 32'h1);
    settle();
    `CHK("pwm sel", 1'b1, pwm)
    give_verdict();
  end
endmodule // motor_operation_data_select_status_test
